// >>> include/branch_stack_pkg.sv
// Purpose: shared constants and types for the branch, stack and port execution unit
// Assumes: one clock state per clock_in cycle
// Notes: state counts are per instruction, taken and not taken
package branch_stack_pkg;

  localparam int CLOCK_PERIOD_NS = 20;

  // opcodes with fixed encodings
  localparam logic [7:0] OPC_JUMP = 8'hc3;
  localparam logic [7:0] OPC_CALL = 8'hcd;
  localparam logic [7:0] OPC_RETURN = 8'hc9;
  localparam logic [7:0] OPC_JUMP_VIA_PAIR = 8'he9;
  localparam logic [7:0] OPC_LOAD_SP_FROM_PAIR = 8'hf9;
  localparam logic [7:0] OPC_STACK_TOP_EXCHANGE = 8'he3;
  localparam logic [7:0] OPC_PORT_IN = 8'hdb;
  localparam logic [7:0] OPC_PORT_OUT = 8'hd3;

  // low bits that identify the opcode families with a field in bits 5:3 (push and pop: bits 5:4)
  localparam logic [1:0] FAMILY_TOP = 2'h3;
  localparam logic [2:0] LOW_JUMP_COND = 3'h2;
  localparam logic [2:0] LOW_CALL_COND = 3'h4;
  localparam logic [2:0] LOW_RETURN_COND = 3'h0;
  localparam logic [2:0] LOW_RESTART = 3'h7;
  localparam logic [3:0] LOW_PUSH = 4'h5;
  localparam logic [3:0] LOW_POP = 4'h1;
  localparam logic [1:0] PAIR_STATUS_WORD = 2'h3;
  localparam logic [1:0] PAIR_HL = 2'h2;

  // state counts
  localparam logic [4:0] STATES_CALL_TAKEN = 5'd18;
  localparam logic [4:0] STATES_CALL_SKIP = 5'd9;
  localparam logic [4:0] STATES_JUMP_TAKEN = 5'd10;
  localparam logic [4:0] STATES_JUMP_SKIP = 5'd7;
  localparam logic [4:0] STATES_RETURN = 5'd10;
  localparam logic [4:0] STATES_RETURN_TAKEN = 5'd12;
  localparam logic [4:0] STATES_RETURN_SKIP = 5'd6;
  localparam logic [4:0] STATES_RESTART = 5'd12;
  localparam logic [4:0] STATES_VIA_PAIR = 5'd6;
  localparam logic [4:0] STATES_LOAD_SP = 5'd6;
  localparam logic [4:0] STATES_EXCHANGE = 5'd16;
  localparam logic [4:0] STATES_PUSH = 5'd12;
  localparam logic [4:0] STATES_POP = 5'd10;
  localparam logic [4:0] STATES_PORT = 5'd10;
  localparam logic [4:0] STATES_UNSUPPORTED = 5'd4;

  // state numbers at which bus transfers run
  localparam logic [4:0] STEP_FIRST = 5'd2;
  localparam logic [4:0] STEP_SECOND = 5'd3;
  localparam logic [4:0] STEP_THIRD = 5'd4;
  localparam logic [4:0] STEP_FOURTH = 5'd5;

  // status word bit positions
  localparam int SW_CARRY = 0;
  localparam int SW_FILL_ONE = 1;
  localparam int SW_PARITY = 2;
  localparam int SW_AUX_CARRY = 4;
  localparam int SW_ZERO = 6;
  localparam int SW_SIGN = 7;

  // reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [3:0] {
    OP_NONE, OP_JUMP, OP_CALL, OP_RETURN, OP_RESTART, OP_VIA_PAIR, OP_LOAD_SP,
    OP_EXCHANGE, OP_PUSH, OP_POP, OP_PORT_IN, OP_PORT_OUT
  } op_type;

endpackage

// >>> src/condition_check.sv
// Purpose: evaluates the 3-bit condition field against the flags
// Assumes: flags are stable levels
// Notes: purely combinational
`timescale 1ns/1ps
module condition_check (
  input wire logic [2:0] condition_field_in,
  input wire logic zero_in,
  input wire logic carry_in,
  input wire logic parity_in,
  input wire logic sign_in,
  output logic holds_out
);
  always_comb begin
    case (condition_field_in[2:1])
      2'h0: holds_out = zero_in;
      2'h1: holds_out = carry_in;
      2'h2: holds_out = parity_in;
      default: holds_out = sign_in;
    endcase
    if (!condition_field_in[0]) begin
      holds_out = !holds_out;
    end
  end
endmodule // condition_check

// >>> src/state_timer.sv
// Purpose: counts the clock states of one instruction
// Assumes: load only while idle
// Notes: count is 0 while idle, runs 1..length
`timescale 1ns/1ps
module state_timer (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [4:0] length_in,
  output logic [4:0] count_out,
  output logic last_out
);
  logic [4:0] length;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      count_out <= 5'h00;
      length <= 5'h00;
    end else if (load_in) begin
      count_out <= 5'h01;
      length <= length_in;
    end else if (count_out != 5'h00) begin
      count_out <= last_out ? 5'h00 : count_out + 5'h01;
    end
  end

  assign last_out = (count_out != 5'h00) && (count_out == length);
endmodule // state_timer

// >>> src/branch_stack_exec.sv
// Purpose: executes branch, stack and port instructions of an 8-bit processor
// Assumes: opcode and operand bytes given with start_in; memory answers reads in the same cycle
// Notes: one clock is one processor state
`timescale 1ns/1ps
module branch_stack_exec
  import branch_stack_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] operand_lo_in,
  input wire logic [7:0] operand_hi_in,
  input wire logic [7:0] data_in,
  output logic busy_out,
  output logic done_out,
  output logic unsupported_out,
  output logic [15:0] addr_out,
  output logic [7:0] data_out,
  output logic data_oe_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic io_select_out,
  output logic [15:0] pc_out,
  output logic [15:0] sp_out,
  output logic [7:0] acc_out,
  output logic [15:0] bc_out,
  output logic [15:0] de_out,
  output logic [15:0] hl_out,
  output logic [7:0] status_word_out
);
  logic [4:0] count, dec_states, plan_step;
  logic last, load, holds, dec_cond, taken, commit;
  logic carry_flag, parity_flag, aux_carry_flag, zero_flag, sign_flag;
  logic plan_rd, plan_wr, plan_io;
  op_type dec_op, op;
  logic [1:0] dec_size, size, register_pair_operand;
  logic [2:0] restart_vector_field;
  logic [7:0] opcode, operand_lo, operand_hi, acc, read_lo, read_hi;
  logic [7:0] push_hi, push_lo, status_word, plan_data;
  logic [7:0] pair_hi [0:2], pair_lo [0:2];
  logic [15:0] pc, sp, return_addr, plan_addr;
  condition_check u_condition_check (.condition_field_in(opcode_in[5:3]), .zero_in(zero_flag),
    .carry_in(carry_flag), .parity_in(parity_flag), .sign_in(sign_flag), .holds_out(holds));
  state_timer u_state_timer (.clock_in(clock_in), .rst_n_in(rst_n_in), .load_in(load), .length_in(dec_states),
    .count_out(count), .last_out(last));
  assign busy_out = (count != 5'h00);
  assign load = start_in && !busy_out;
  assign done_out = last;
  assign commit = last;
  assign unsupported_out = last && (op == OP_NONE);
  // opcode decode, taken from the inputs at the start edge
  always_comb begin
    dec_op = OP_NONE;
    dec_cond = 1'b0;
    dec_size = 2'd1;
    if (opcode_in == OPC_JUMP) begin
      dec_op = OP_JUMP;
      dec_size = 2'd3;
    end else if (opcode_in == OPC_CALL) begin
      dec_op = OP_CALL;
      dec_size = 2'd3;
    end else if (opcode_in == OPC_RETURN) begin
      dec_op = OP_RETURN;
    end else if (opcode_in == OPC_JUMP_VIA_PAIR) begin
      dec_op = OP_VIA_PAIR;
    end else if (opcode_in == OPC_LOAD_SP_FROM_PAIR) begin
      dec_op = OP_LOAD_SP;
    end else if (opcode_in == OPC_STACK_TOP_EXCHANGE) begin
      dec_op = OP_EXCHANGE;
    end else if (opcode_in == OPC_PORT_IN) begin
      dec_op = OP_PORT_IN;
      dec_size = 2'd2;
    end else if (opcode_in == OPC_PORT_OUT) begin
      dec_op = OP_PORT_OUT;
      dec_size = 2'd2;
    end else if (opcode_in[7:6] != FAMILY_TOP) begin
      dec_op = OP_NONE;
    end else if (opcode_in[2:0] == LOW_JUMP_COND) begin
      dec_op = OP_JUMP;
      dec_cond = 1'b1;
      dec_size = 2'd3;
    end else if (opcode_in[2:0] == LOW_CALL_COND) begin
      dec_op = OP_CALL;
      dec_cond = 1'b1;
      dec_size = 2'd3;
    end else if (opcode_in[2:0] == LOW_RETURN_COND) begin
      dec_op = OP_RETURN;
      dec_cond = 1'b1;
    end else if (opcode_in[2:0] == LOW_RESTART) begin
      dec_op = OP_RESTART;
    end else if (opcode_in[3:0] == LOW_PUSH) begin
      dec_op = OP_PUSH;
    end else if (opcode_in[3:0] == LOW_POP) begin
      dec_op = OP_POP;
    end
  end
  always_comb begin
    case (dec_op)
      OP_JUMP: dec_states = (!dec_cond || holds) ? STATES_JUMP_TAKEN : STATES_JUMP_SKIP;
      OP_CALL: dec_states = (!dec_cond || holds) ? STATES_CALL_TAKEN : STATES_CALL_SKIP;
      OP_RETURN: dec_states = !dec_cond ? STATES_RETURN : (holds ? STATES_RETURN_TAKEN : STATES_RETURN_SKIP);
      OP_RESTART: dec_states = STATES_RESTART;
      OP_VIA_PAIR: dec_states = STATES_VIA_PAIR;
      OP_LOAD_SP: dec_states = STATES_LOAD_SP;
      OP_EXCHANGE: dec_states = STATES_EXCHANGE;
      OP_PUSH: dec_states = STATES_PUSH;
      OP_POP: dec_states = STATES_POP;
      OP_PORT_IN: dec_states = STATES_PORT;
      OP_PORT_OUT: dec_states = STATES_PORT;
      default: dec_states = STATES_UNSUPPORTED;
    endcase
  end
  // instruction latch
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      op <= OP_NONE;
      taken <= 1'b0;
      size <= 2'd1;
      opcode <= 8'h00;
      operand_lo <= 8'h00;
      operand_hi <= 8'h00;
    end else if (load) begin
      op <= dec_op;
      taken <= !dec_cond || holds;
      size <= dec_size;
      opcode <= opcode_in;
      operand_lo <= operand_lo_in;
      operand_hi <= operand_hi_in;
    end
  end
  assign register_pair_operand = opcode[5:4];
  assign restart_vector_field = opcode[5:3];
  assign return_addr = pc + {14'h0000, size};
  always_comb begin
    status_word = 8'h00;
    status_word[SW_CARRY] = carry_flag;
    status_word[SW_FILL_ONE] = 1'b1;
    status_word[SW_PARITY] = parity_flag;
    status_word[SW_AUX_CARRY] = aux_carry_flag;
    status_word[SW_ZERO] = zero_flag;
    status_word[SW_SIGN] = sign_flag;
  end
  // bytes pushed: return address, register pair or status word
  always_comb begin
    push_hi = return_addr[15:8];
    push_lo = return_addr[7:0];
    if (op == OP_PUSH) begin
      if (register_pair_operand == PAIR_STATUS_WORD) begin
        push_hi = acc;
        push_lo = status_word;
      end else begin
        push_hi = pair_hi[register_pair_operand];
        push_lo = pair_lo[register_pair_operand];
      end
    end
  end
  // bus plan for the next state; outputs are registered one edge ahead
  assign plan_step = count + 5'h01;
  always_comb begin
    plan_addr = 16'h0000;
    plan_data = 8'h00;
    plan_rd = 1'b0;
    plan_wr = 1'b0;
    plan_io = 1'b0;
    if (busy_out && !last && taken) begin
      case (op)
        OP_CALL, OP_RESTART, OP_PUSH: begin
          if (plan_step == STEP_FIRST) begin
            plan_addr = sp - 16'h0001;
            plan_data = push_hi;
            plan_wr = 1'b1;
          end else if (plan_step == STEP_SECOND) begin
            plan_addr = sp - 16'h0002;
            plan_data = push_lo;
            plan_wr = 1'b1;
          end
        end
        OP_RETURN, OP_POP, OP_EXCHANGE: begin
          if (plan_step == STEP_FIRST) begin
            plan_addr = sp;
            plan_rd = 1'b1;
          end else if (plan_step == STEP_SECOND) begin
            plan_addr = sp + 16'h0001;
            plan_rd = 1'b1;
          end else if (op == OP_EXCHANGE && plan_step == STEP_THIRD) begin
            plan_addr = sp;
            plan_data = pair_lo[PAIR_HL];
            plan_wr = 1'b1;
          end else if (op == OP_EXCHANGE && plan_step == STEP_FOURTH) begin
            plan_addr = sp + 16'h0001;
            plan_data = pair_hi[PAIR_HL];
            plan_wr = 1'b1;
          end
        end
        OP_PORT_IN, OP_PORT_OUT: begin
          if (plan_step == STEP_FIRST) begin
            plan_addr = {operand_lo, operand_lo};
            plan_io = 1'b1;
            plan_rd = (op == OP_PORT_IN);
            plan_wr = (op == OP_PORT_OUT);
            plan_data = acc;
          end
        end
        default: plan_io = 1'b0;
      endcase
    end
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      addr_out <= 16'h0000;
      data_out <= 8'h00;
      data_oe_out <= 1'b0;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      io_select_out <= 1'b0;
    end else begin
      addr_out <= plan_addr;
      data_out <= plan_wr ? plan_data : 8'h00;
      data_oe_out <= plan_wr;
      mem_rd_out <= plan_rd;
      mem_wr_out <= plan_wr;
      io_select_out <= plan_io;
    end
  end
  // read data is sampled at the end of its read state; no wait states
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      read_lo <= 8'h00;
      read_hi <= 8'h00;
    end else if (mem_rd_out && count == STEP_FIRST) begin
      read_lo <= data_in;
    end else if (mem_rd_out) begin
      read_hi <= data_in;
    end
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pc <= PC_RESET;
    end else if (commit) begin
      if (taken && (op == OP_JUMP || op == OP_CALL)) begin
        pc <= {operand_hi, operand_lo};
      end else if (taken && op == OP_RETURN) begin
        pc <= {read_hi, read_lo};
      end else if (op == OP_RESTART) begin
        pc <= {10'h000, restart_vector_field, 3'h0};
      end else if (op == OP_VIA_PAIR) begin
        pc <= {pair_hi[PAIR_HL], pair_lo[PAIR_HL]};
      end else begin
        pc <= return_addr;
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      sp <= SP_RESET;
    end else if (commit) begin
      if (taken && (op == OP_CALL || op == OP_RESTART || op == OP_PUSH)) begin
        sp <= sp - 16'h0002;
      end else if (taken && (op == OP_RETURN || op == OP_POP)) begin
        sp <= sp + 16'h0002;
      end else if (op == OP_LOAD_SP) begin
        sp <= {pair_hi[PAIR_HL], pair_lo[PAIR_HL]};
      end
    end
  end
  // register pairs; the stack pointer encoding means status word, never the pointer
  for (genvar i = 0; i < 3; i++) begin : g_pair
    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        pair_hi[i] <= REG_RESET;
        pair_lo[i] <= REG_RESET;
      end else if (commit && op == OP_POP && register_pair_operand == 2'(i)) begin
        pair_lo[i] <= read_lo;
        pair_hi[i] <= read_hi;
      end else if (commit && op == OP_EXCHANGE && i == int'(PAIR_HL)) begin
        pair_lo[i] <= read_lo;
        pair_hi[i] <= read_hi;
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      acc <= REG_RESET;
    end else if (commit && op == OP_PORT_IN) begin
      acc <= read_lo;
    end else if (commit && op == OP_POP && register_pair_operand == PAIR_STATUS_WORD) begin
      acc <= read_hi;
    end
  end
  // flags change only on a status word pop
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      carry_flag <= 1'b0;
      parity_flag <= 1'b0;
      aux_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      sign_flag <= 1'b0;
    end else if (commit && op == OP_POP && register_pair_operand == PAIR_STATUS_WORD) begin
      carry_flag <= read_lo[SW_CARRY];
      parity_flag <= read_lo[SW_PARITY];
      aux_carry_flag <= read_lo[SW_AUX_CARRY];
      zero_flag <= read_lo[SW_ZERO];
      sign_flag <= read_lo[SW_SIGN];
    end
  end
  assign pc_out = pc;
  assign sp_out = sp;
  assign acc_out = acc;
  assign bc_out = {pair_hi[0], pair_lo[0]};
  assign de_out = {pair_hi[1], pair_lo[1]};
  assign hl_out = {pair_hi[PAIR_HL], pair_lo[PAIR_HL]};
  assign status_word_out = status_word;
endmodule // branch_stack_exec

// >>> sim/mem_port_model.sv
// Purpose: stack/program memory and port model on the far side of the data bus
// Assumes: reads answered in the strobe cycle, writes taken at its closing edge
// Notes: an idle bus shows the inverse of the last byte, so no stale value passes
`timescale 1ns/1ps
module mem_port_model (
  input wire logic clock_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic io_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  initial begin
    last = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i ^ (i >> 8));
    end
  end
  // a port answers with a fixed pattern of its number
  assign rdata_out = !rd_in ? ~last : io_in ? addr_in[7:0] ^ 8'ha5 : mem[addr_in[15:0]];
  always @(posedge clock_in) begin
    if (rd_in) begin
      last <= rdata_out;
    end
    // port writes are accepted and dropped
    if (wr_in && !io_in) begin
      mem[addr_in] <= wdata_in;
    end
  end
endmodule // mem_port_model

// >>> sim/branch_stack_exec_checker.sv
// Purpose: temporal checks on the execution unit's ports
// Assumes: one clock, synchronous active-low reset
// Notes: counts run from the edge that takes start_in
`timescale 1ns/1ps
module branch_stack_exec_checker
  import branch_stack_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [7:0] opcode_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [15:0] addr_out,
  input wire logic [7:0] data_out,
  input wire logic data_oe_out,
  input wire logic mem_wr_out,
  input wire logic io_select_out,
  input wire logic [15:0] pc_out,
  input wire logic [15:0] sp_out,
  input wire logic [7:0] acc_out,
  input wire logic [15:0] hl_out,
  input wire logic [7:0] status_word_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  logic taken;
  assign taken = start_in && !busy_out;
  chk_call_full_len: assert property (taken && opcode_in == OPC_CALL |-> ##18 done_out)
    else $error("call did not finish in 18 states");
  chk_jump_cond_len: assert property (taken && opcode_in[7:6] == FAMILY_TOP && opcode_in[2:0] == LOW_JUMP_COND
    |-> (##7 done_out) or (##10 done_out)) else $error("conditional jump length wrong");
  chk_port_in_len: assert property (taken && opcode_in == OPC_PORT_IN |-> ##10 done_out)
    else $error("port input length wrong");
  chk_exchange_sp_kept: assert property (taken && opcode_in == OPC_STACK_TOP_EXCHANGE
    |-> ##16 done_out ##1 sp_out == $past(sp_out, 17)) else $error("exchange timing or stack pointer wrong");
  chk_load_sp_hl: assert property (taken && opcode_in == OPC_LOAD_SP_FROM_PAIR
    |-> ##6 done_out ##1 sp_out == $past(hl_out, 7)) else $error("stack pointer load wrong");
  chk_via_pair_pc: assert property (taken && opcode_in == OPC_JUMP_VIA_PAIR |-> ##7 pc_out == $past(hl_out, 7))
    else $error("jump via pair target wrong");
  chk_out_drives_acc: assert property (mem_wr_out && io_select_out |-> data_oe_out && data_out == acc_out)
    else $error("port output byte is not the accumulator");
  chk_port_addr_dup: assert property (io_select_out |-> addr_out[15:8] == addr_out[7:0])
    else $error("port address not on both address bytes");
  chk_flags_only_commit: assert property ($changed(status_word_out) |-> $past(done_out))
    else $error("flags changed outside a commit");
  chk_stack_first_write: assert property (mem_wr_out && !io_select_out && !$past(mem_wr_out)
    |-> addr_out == sp_out - 16'd1 || addr_out == sp_out) else $error("first stack write address wrong");
  cov_call: cover property (taken && opcode_in == OPC_CALL);
  cov_port_in: cover property (taken && opcode_in == OPC_PORT_IN);
  cov_exchange: cover property (taken && opcode_in == OPC_STACK_TOP_EXCHANGE);
  cov_flag_pop: cover property ($changed(status_word_out));
endmodule // branch_stack_exec_checker
bind branch_stack_exec branch_stack_exec_checker u_branch_stack_exec_checker (.clock_in, .rst_n_in, .start_in,
  .opcode_in, .busy_out, .done_out, .addr_out, .data_out, .data_oe_out, .mem_wr_out, .io_select_out, .pc_out,
  .sp_out, .acc_out, .hl_out, .status_word_out);

// >>> sim/branch_stack_exec_tb_top.sv
// Purpose: random instruction stream against a reference model of the unit
// Assumes: memory and ports modelled by mem_port_model
// Notes: garbage start requests are thrown in while busy to probe refusal
`timescale 1ns/1ps
module branch_stack_exec_tb_top
  import branch_stack_pkg::*;
;
  typedef struct {logic [15:0] pc, sp, bc, de, hl; logic [7:0] acc, sw; int n;} note_type;
  typedef struct {logic [15:0] a; logic [7:0] d; logic io;} wnote_type;
  logic clock_in, rst_n_in, start_in;
  logic [7:0] opcode_in, operand_lo_in, operand_hi_in, data_in, data_out, acc_out, status_word_out;
  logic busy_out, done_out, unsupported_out, data_oe_out, mem_rd_out, mem_wr_out, io_select_out;
  logic [15:0] addr_out, pc_out, sp_out, bc_out, de_out, hl_out;
  logic [15:0] m_pc, m_sp;
  logic [15:0] m_r [0:3];
  logic [7:0] m_a, m_f;
  logic [7:0] sm [0:65535];
  note_type q [$];
  wnote_type wq [$];
  note_type e;
  wnote_type w;
  int error_cnt, n_tests, cnt, seed;
  branch_stack_exec u_branch_stack_exec (.clock_in, .rst_n_in, .start_in, .opcode_in, .operand_lo_in,
    .operand_hi_in, .data_in, .busy_out, .done_out, .unsupported_out, .addr_out, .data_out, .data_oe_out,
    .mem_rd_out, .mem_wr_out, .io_select_out, .pc_out, .sp_out, .acc_out, .bc_out, .de_out, .hl_out,
    .status_word_out);
  mem_port_model u_mem_port_model (.clock_in(clock_in), .addr_in(addr_out), .wdata_in(data_out),
    .rd_in(mem_rd_out), .wr_in(mem_wr_out), .io_in(io_select_out), .rdata_out(data_in));
  always #10 clock_in = ~clock_in;
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic io);
    wq.push_back('{a, d, io});
    if (!io) sm[a] = d;
  endtask
  task automatic push16(input logic [15:0] v);
    wr(m_sp - 16'd1, v[15:8], 1'b0);
    wr(m_sp - 16'd2, v[7:0], 1'b0);
    m_sp = m_sp - 16'd2;
  endtask
  task automatic pop16(output logic [15:0] v);
    v = {sm[m_sp + 16'd1], sm[m_sp]};
    m_sp = m_sp + 16'd2;
  endtask
  // reference model: notes writes and the final state before the request goes out
  task automatic step(input logic [7:0] op, input logic [7:0] lo, input logic [7:0] hi);
    logic [15:0] nxt, np, v;
    logic [3:0] fl;
    logic t;
    int n;
    fl = {m_f[7], m_f[2], m_f[0], m_f[6]};
    t = fl[op[5:4]] == op[3];
    nxt = m_pc + 16'd1;
    if (op == OPC_CALL || op == OPC_JUMP || op[2:0] == 3'h2 || op[2:0] == 3'h4) nxt = m_pc + 16'd3;
    if (op == OPC_PORT_IN || op == OPC_PORT_OUT) nxt = m_pc + 16'd2;
    n = 4;
    // opcodes outside this group still step over their one byte
    np = m_pc + 16'd1;
    if (op[7:6] == 2'h3) begin
      np = nxt;
      if (op == OPC_JUMP || op[2:0] == 3'h2) begin
        n = (op == OPC_JUMP || t) ? 10 : 7;
        if (n == 10) np = {hi, lo};
      end else if (op == OPC_CALL || op[2:0] == 3'h4) begin
        n = (op == OPC_CALL || t) ? 18 : 9;
        if (n == 18) push16(nxt);
        if (n == 18) np = {hi, lo};
      end else if (op == OPC_RETURN || op[2:0] == 3'h0) begin
        n = (op == OPC_RETURN) ? 10 : t ? 12 : 6;
        if (n != 6) pop16(np);
      end else if (op[2:0] == 3'h7) begin
        n = 12;
        push16(nxt);
        np = {10'h0, op[5:3], 3'h0};
      end else if (op == OPC_JUMP_VIA_PAIR) begin
        n = 6;
        np = m_r[2];
      end else if (op == OPC_LOAD_SP_FROM_PAIR) begin
        n = 6;
        m_sp = m_r[2];
      end else if (op == OPC_STACK_TOP_EXCHANGE) begin
        n = 16;
        v = {sm[m_sp + 16'd1], sm[m_sp]};
        wr(m_sp, m_r[2][7:0], 1'b0);
        wr(m_sp + 16'd1, m_r[2][15:8], 1'b0);
        m_r[2] = v;
      end else if (op[3:0] == 4'h5) begin
        n = 12;
        push16(op[5:4] == 2'h3 ? {m_a, m_f} : m_r[op[5:4]]);
      end else if (op[3:0] == 4'h1) begin
        n = 10;
        pop16(v);
        if (op[5:4] == 2'h3) m_a = v[15:8];
        if (op[5:4] == 2'h3) m_f = (v[7:0] & 8'hd5) | 8'h02;
        else m_r[op[5:4]] = v;
      end else if (op == OPC_PORT_IN) begin
        n = 10;
        m_a = lo ^ 8'ha5;
      end else if (op == OPC_PORT_OUT) begin
        n = 10;
        wr({lo, lo}, m_a, 1'b1);
      end else begin
        np = nxt;
      end
    end
    m_pc = np;
    q.push_back('{m_pc, m_sp, m_r[0], m_r[1], m_r[2], m_a, m_f, n});
  endtask
  task automatic exec(input logic [7:0] op, input logic [7:0] lo, input logic [7:0] hi);
    int k;
    step(op, lo, hi);
    @(posedge clock_in);
    start_in <= 1'b1;
    opcode_in <= op;
    operand_lo_in <= lo;
    operand_hi_in <= hi;
    k = 0;
    do begin
      @(posedge clock_in);
      start_in <= 1'($random(seed));
      opcode_in <= 8'($random(seed));
      k++;
      #1;
    end while (done_out !== 1'b1 && k < 30);
    if (k >= 30) begin
      error_cnt++;
      $display("MISMATCH %0t no done pulse", $time);
    end
  endtask
  always @(posedge clock_in) cnt <= (start_in && !busy_out) ? 1 : cnt + 1;
  always @(negedge clock_in) begin
    if (mem_wr_out === 1'b1) begin
      w = wq.pop_front();
      n_tests++;
      if (!(addr_out === w.a && data_out === w.d && io_select_out === w.io && data_oe_out === 1'b1)) begin
        error_cnt++;
        $display("MISMATCH %0t bus write", $time);
      end
    end
    if (done_out === 1'b1) begin
      e = q.pop_front();
      n_tests++;
      if (!(cnt == e.n && unsupported_out === (e.n == 4))) begin
        error_cnt++;
        $display("MISMATCH %0t state count", $time);
      end
      @(posedge clock_in);
      #1;
      n_tests++;
      if (!(pc_out === e.pc && sp_out === e.sp && bc_out === e.bc && de_out === e.de && hl_out === e.hl
          && acc_out === e.acc && status_word_out === e.sw)) begin
        error_cnt++;
        $display("MISMATCH %0t registers", $time);
      end
    end
  end
  task automatic wrap_up();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #900000;
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    seed = 56171;
    clock_in = 1'b0;
    rst_n_in = 1'b0;
    start_in = 1'b0;
    opcode_in = 8'h00;
    operand_lo_in = 8'h00;
    operand_hi_in = 8'h00;
    error_cnt = 0;
    n_tests = 0;
    cnt = 0;
    m_pc = 16'h0000;
    m_sp = 16'h0000;
    m_a = 8'h00;
    m_f = 8'h02;
    m_r = '{16'h0, 16'h0, 16'h0, 16'h0};
    for (int i = 0; i < 65536; i++) sm[i] = 8'(i ^ (i >> 8));
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    #1;
    n_tests++;
    if (!(status_word_out === 8'h02 && pc_out === 16'h0 && sp_out === 16'h0 && busy_out === 1'b0)) begin
      error_cnt++;
      $display("MISMATCH %0t reset state", $time);
    end
    // mostly the 0xc0..0xff block, some other opcodes for the refused path
    for (int i = 0; i < 1500; i++) begin
      exec((i % 8 == 0) ? 8'($random(seed)) : {2'h3, 6'($random(seed))}, 8'($random(seed)), 8'($random(seed)));
    end
    // no stray request may start an instruction that nobody expects
    start_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    wrap_up();
  end
endmodule // branch_stack_exec_tb_top
